// ### hdl/tpa_params.svh
`ifndef TPA_PARAMS_SVH
`define TPA_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TPA_ADDR_CTRL     8'h00
`define TPA_ADDR_STATUS   8'h04
`define TPA_ADDR_MASK     8'h08
`define TPA_ADDR_INFO     8'h0c

// ****************************************
// field positions
// ****************************************
`define TPA_CTRL_SEL_LSB  0
`define TPA_CTRL_SEL_MSB  1
`define TPA_CTRL_RATE     2
`define TPA_STAT_CFG_BAD  4
`define TPA_INFO_PRST     5

// ****************************************
// reset values
// ****************************************
`define TPA_CTRL_RST      3'h0
`define TPA_STATUS_RST    5'h00
`define TPA_MASK_RST      5'h00

// ****************************************
// multipliers and counts
// ****************************************
`define TPA_MULT_HALF     5'h14
`define TPA_MULT_FULL     5'h0a
`define TPA_PRST_MIN      2'h2

`endif

// ### hdl/tpa_pkg.sv
package tpa_pkg;
  // three-level select, coded in two bits
  typedef enum logic [1:0] {
    TPA_SEL_LOW  = 2'h0,
    TPA_SEL_MID  = 2'h1,
    TPA_SEL_HIGH = 2'h2
  } tpa_sel_t;

  // alignment state, one-hot
  typedef enum logic [2:0] {
    TPA_ST_BYPASS = 3'h1,
    TPA_ST_ALIGN  = 3'h2,
    TPA_ST_RUN    = 3'h4
  } tpa_state_t;
endpackage

// ### hdl/tpa_sync_edge.sv
// two-stage synchroniser with edge detection on the settled stage
module tpa_sync_edge #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_ff;  // first stage, read only by sync_ff
  logic [W-1:0] sync_ff;  // settled stage
  logic [W-1:0] prev_ff;  // one cycle older, for edges

  // ****************************************
  // registers only
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~prev_ff;
  assign fall  = ~sync_ff & prev_ff;
endmodule

// ### hdl/tpa_phase_fifo.sv
// small phase-align fifo; recentre puts read half a depth behind write
module tpa_phase_fifo #(
  parameter int W  = 10,
  parameter int AW = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd_en,
  input  wire logic         recentre,
  output logic      [W-1:0] rd_data,
  output logic              rd_valid,
  output logic              underflow,
  output logic              overflow
);
  localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);
  localparam logic [AW:0] HALF  = (AW+1)'(1 << (AW - 1));

  logic [W-1:0]  mem [0:(1<<AW)-1];  // character store
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic [W-1:0]  rd_data_ff, nxt_rd_data;
  logic          rd_valid_ff, nxt_rd_valid;
  logic          unf_ff, nxt_unf;
  logic          ovf_ff, nxt_ovf;
  logic          do_wr;
  logic          do_rd;

  // ****************************************
  // pointer and flag next state
  // ****************************************
  always_comb begin
    do_rd        = rd_en && (cnt_ff != '0);
    do_wr        = wr_en && ((cnt_ff != DEPTH) || do_rd);
    nxt_wr_ptr   = do_wr ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr   = do_rd ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_cnt      = cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    nxt_rd_data  = do_rd ? mem[rd_ptr_ff] : rd_data_ff;
    nxt_rd_valid = do_rd;
    nxt_unf      = rd_en && (cnt_ff == '0);         // pointer collision on read
    nxt_ovf      = wr_en && !do_wr;                 // pointer collision on write
    if (recentre) begin
      // stale slots may repeat, characters may be lost
      // measured from the post-write pointer so cnt matches the pointers
      nxt_rd_ptr = nxt_wr_ptr - HALF[AW-1:0];
      nxt_cnt    = HALF;
      nxt_unf    = 1'b0;
      nxt_ovf    = 1'b0;
    end
  end

  // ****************************************
  // registers only
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      cnt_ff      <= '0;
      rd_data_ff  <= '0;
      rd_valid_ff <= 1'b0;
      unf_ff      <= 1'b0;
      ovf_ff      <= 1'b0;
    end else begin
      wr_ptr_ff   <= nxt_wr_ptr;
      rd_ptr_ff   <= nxt_rd_ptr;
      cnt_ff      <= nxt_cnt;
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      unf_ff      <= nxt_unf;
      ovf_ff      <= nxt_ovf;
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= wr_data;
    end
  end

  assign rd_data   = rd_data_ff;
  assign rd_valid  = rd_valid_ff;
  assign underflow = unf_ff;
  assign overflow  = ovf_ff;

  property p_recentre_half;
    @(posedge clk) disable iff (rst) recentre |=> (cnt_ff == HALF);
  endproperty
  a_recentre_half: assert property (p_recentre_half)
    else $error("fifo not recentred to half depth");

  property p_overflow_cause;
    @(posedge clk) disable iff (rst)
      (wr_en && !rd_en && cnt_ff == DEPTH && !recentre) |=> overflow;
  endproperty
  a_overflow_cause: assert property (p_overflow_cause)
    else $error("write into full fifo not flagged");
endmodule

// ### hdl/tpa_tx_input_clocking.sv
// Function
// - half-rate reference: use both reference edges
// - phase reset sampled on reference rising edges
// - reset low: buffers re-adjust transfer timing; in half-rate reference mode only while a lane error is set
// - reset high: phase relation frozen, normal run
// - half-rate reference mode: reset clears faults
// - realignment may insert or drop characters
// - select and rate low: bypass, ignore reset
// - clock select picks input register clock
// - output clock at one or two times reference
// - output clock synchronous to character clock
// - multiplier twenty at half, ten full rate
// - sticky lane error until sync or reset; selecting bypass also clears it
//
// Local design decisions: register access over APB and the placing of the registers.
module tpa_tx_input_clocking
  import tpa_pkg::*;
#(
  parameter int LANES = 4,
  parameter int AW    = 2,
  parameter int CW    = 16
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  reference_clock_in,
  input  wire logic [LANES-1:0]      lane_input_clock,
  input  wire logic                  transmit_phase_reset_n,
  input  wire logic [LANES-1:0][7:0] lane_char_data_in,
  input  wire logic [LANES-1:0][1:0] lane_char_control_in,
  input  wire logic [LANES-1:0]      lane_word_sync_sent,
  output logic      [LANES-1:0][7:0] enc_char_data,
  output logic      [LANES-1:0][1:0] enc_char_control,
  output logic      [LANES-1:0]      enc_char_valid,
  output logic      [LANES-1:0]      lane_error_flag,
  output logic                       character_rate_clock_out_p,
  output logic                       character_rate_clock_out_n,
  output logic      [4:0]            synth_multiplier,
  output logic                       irq
);
  `include "tpa_params.svh"

  localparam int DW = LANES * 10;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [LANES+1:0] clk_lvl;          // {reset_n, lanes, ref}
  logic [LANES+1:0] clk_rise;
  logic [LANES+1:0] clk_fall;
  logic [DW-1:0]    din_sync;         // {controls, data}
  logic [LANES-1:0] lane_rise;
  logic             ref_rise;
  logic             ref_fall;
  logic             prst_lvl_n;

  tpa_sync_edge #(.W(LANES + 2)) u_clk_sync (
    .clk   (sys_clk),
    .rst   (rst),
    .din   ({transmit_phase_reset_n, lane_input_clock, reference_clock_in}),
    .level (clk_lvl),
    .rise  (clk_rise),
    .fall  (clk_fall)
  );

  // data takes the same two stages, so it lines up with the clock edges
  tpa_sync_edge #(.W(DW)) u_data_sync (
    .clk   (sys_clk),
    .rst   (rst),
    .din   ({lane_char_control_in, lane_char_data_in}),
    .level (din_sync),
    .rise  (),
    .fall  ()
  );

  assign ref_rise   = clk_rise[0];
  assign ref_fall   = clk_fall[0];
  assign lane_rise  = clk_rise[LANES:1];
  assign prst_lvl_n = clk_lvl[LANES+1];

  // ****************************************
  // configuration decode
  // ****************************************
  logic [2:0] ctrl_ff, nxt_ctrl;      // select and rate
  tpa_sel_t   sel;
  logic       rate;                   // high: half-rate reference
  logic       bypass;
  logic       half_ref;
  logic       cfg_bad;
  logic       char_tick;              // internal character clock enable

  always_comb begin
    sel       = tpa_sel_t'(ctrl_ff[`TPA_CTRL_SEL_MSB:`TPA_CTRL_SEL_LSB]);
    rate      = ctrl_ff[`TPA_CTRL_RATE];
    bypass    = (sel == TPA_SEL_LOW) && !rate;
    half_ref  = (sel == TPA_SEL_LOW) && rate;
    cfg_bad   = rate && (sel != TPA_SEL_LOW);            // flagged, not blocked
    char_tick = ref_rise || (rate && ref_fall);
  end

  // ****************************************
  // input register write strobes
  // ****************************************
  logic [LANES-1:0] wr_stb;

  // code 3 of the select is treated like mid
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      case (sel)
        TPA_SEL_LOW:  wr_stb[i] = char_tick;
        TPA_SEL_HIGH: wr_stb[i] = lane_rise[0];
        default:      wr_stb[i] = lane_rise[i];
      endcase
    end
  end

  // ****************************************
  // phase reset sampling and alignment state
  // ****************************************
  logic [1:0] prst_cnt_ff, nxt_prst_cnt;   // consecutive low samples
  logic       prst_act_ff, nxt_prst_act;
  tpa_state_t state_ff, nxt_state;
  logic       recentre;
  logic [LANES-1:0] err_ff, nxt_err;

  always_comb begin
    nxt_prst_cnt = prst_cnt_ff;
    nxt_prst_act = prst_act_ff;
    if (ref_rise) begin
      if (!prst_lvl_n) begin
        nxt_prst_cnt = (prst_cnt_ff == `TPA_PRST_MIN) ? prst_cnt_ff : prst_cnt_ff + 2'h1;
      end else begin
        nxt_prst_cnt = 2'h0;
      end
      nxt_prst_act = (nxt_prst_cnt == `TPA_PRST_MIN);
    end
    // buffer bypassed: the phase reset pin is ignored outright
    if (bypass) begin
      nxt_prst_cnt = 2'h0;
      nxt_prst_act = 1'b0;
    end
    case (state_ff)
      TPA_ST_BYPASS: nxt_state = bypass ? TPA_ST_BYPASS : TPA_ST_RUN;
      TPA_ST_ALIGN:  nxt_state = prst_act_ff ? TPA_ST_ALIGN : TPA_ST_RUN;
      TPA_ST_RUN:    nxt_state = prst_act_ff ? TPA_ST_ALIGN : TPA_ST_RUN;
      default:       nxt_state = TPA_ST_RUN;
    endcase
    if (bypass) begin
      nxt_state = TPA_ST_BYPASS;
    end
  end

  // half-rate reference mode stays aligned; reset recentres there only while a lane error is set
  assign recentre = (state_ff == TPA_ST_ALIGN) && !bypass
                    && (!half_ref || (|err_ff));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prst_cnt_ff <= 2'h0;
      prst_act_ff <= 1'b0;
      state_ff    <= TPA_ST_BYPASS;
    end else begin
      prst_cnt_ff <= nxt_prst_cnt;
      prst_act_ff <= nxt_prst_act;
      state_ff    <= nxt_state;
    end
  end

  // ****************************************
  // phase-align buffers
  // ****************************************
  logic [LANES-1:0][9:0] pf_data;
  logic [LANES-1:0]      pf_valid;
  logic [LANES-1:0]      pf_unf;
  logic [LANES-1:0]      pf_ovf;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    tpa_phase_fifo #(.W(10), .AW(AW)) u_fifo (
      .clk       (sys_clk),
      .rst       (rst),
      .wr_en     (wr_stb[g] && !bypass),
      .wr_data   ({din_sync[LANES*8+g*2 +: 2], din_sync[g*8 +: 8]}),
      .rd_en     (char_tick && !bypass),
      .recentre  (recentre),
      .rd_data   (pf_data[g]),
      .rd_valid  (pf_valid[g]),
      .underflow (pf_unf[g]),
      .overflow  (pf_ovf[g])
    );
  end

  // ****************************************
  // encoder side characters
  // ****************************************
  logic [LANES-1:0][7:0] enc_data_ff, nxt_enc_data;
  logic [LANES-1:0][1:0] enc_ctl_ff, nxt_enc_ctl;
  logic [LANES-1:0]      enc_vld_ff, nxt_enc_vld;

  // bypass takes the input register straight through
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      if (bypass) begin
        nxt_enc_data[i] = wr_stb[i] ? din_sync[i*8 +: 8] : enc_data_ff[i];
        nxt_enc_ctl[i]  = wr_stb[i] ? din_sync[LANES*8+i*2 +: 2] : enc_ctl_ff[i];
        nxt_enc_vld[i]  = wr_stb[i];
      end else begin
        nxt_enc_data[i] = pf_valid[i] ? pf_data[i][7:0] : enc_data_ff[i];
        nxt_enc_ctl[i]  = pf_valid[i] ? pf_data[i][9:8] : enc_ctl_ff[i];
        nxt_enc_vld[i]  = pf_valid[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enc_data_ff <= '0;
      enc_ctl_ff  <= '0;
      enc_vld_ff  <= '0;
    end else begin
      enc_data_ff <= nxt_enc_data;
      enc_ctl_ff  <= nxt_enc_ctl;
      enc_vld_ff  <= nxt_enc_vld;
    end
  end

  // ****************************************
  // lane error flags
  // ****************************************
  logic [LANES-1:0] lane_evt;

  // set beats clear, so a fault in the clearing cycle is kept
  always_comb begin
    lane_evt = (pf_unf | pf_ovf) & {LANES{!bypass}};
    for (int i = 0; i < LANES; i++) begin
      if (lane_evt[i]) begin
        nxt_err[i] = 1'b1;
      end else if (lane_word_sync_sent[i] || prst_act_ff || bypass) begin
        nxt_err[i] = 1'b0;
      end else begin
        nxt_err[i] = err_ff[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      err_ff <= '0;
    end else begin
      err_ff <= nxt_err;
    end
  end

  // ****************************************
  // character rate output clock
  // ****************************************
  logic [CW-1:0] tcnt_ff, nxt_tcnt;     // cycles since last tick
  logic [CW-1:0] per_ff, nxt_per;       // measured tick period
  logic          ckp_ff, nxt_ckp;
  logic          ckn_ff, nxt_ckn;
  logic [4:0]    mult_ff, nxt_mult;

  // high for the first half of each measured character period
  always_comb begin
    nxt_tcnt = (tcnt_ff == '1) ? tcnt_ff : tcnt_ff + 1'b1;
    nxt_per  = per_ff;
    if (char_tick) begin
      nxt_tcnt = '0;
      nxt_per  = tcnt_ff + 1'b1;
    end
    nxt_ckp  = (nxt_tcnt < (per_ff >> 1));
    nxt_ckn  = !nxt_ckp;
    nxt_mult = rate ? `TPA_MULT_HALF : `TPA_MULT_FULL;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tcnt_ff <= '0;
      per_ff  <= '0;
      ckp_ff  <= 1'b0;
      ckn_ff  <= 1'b1;
      mult_ff <= `TPA_MULT_FULL;
    end else begin
      tcnt_ff <= nxt_tcnt;
      per_ff  <= nxt_per;
      ckp_ff  <= nxt_ckp;
      ckn_ff  <= nxt_ckn;
      mult_ff <= nxt_mult;
    end
  end

  // ****************************************
  // apb slave, status, mask, interrupt
  // ****************************************
  logic [4:0]  stat_ff, nxt_stat;       // sticky, write one to clear
  logic [4:0]  mask_ff, nxt_mask;
  logic        rdy_ff, nxt_rdy;
  logic        err_rsp_ff, nxt_err_rsp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        irq_ff, nxt_irq;
  logic        commit;

  // one wait state: pready rises the cycle after the access phase starts
  always_comb begin
    commit      = psel && penable && rdy_ff;
    nxt_rdy     = psel && penable && !rdy_ff;
    nxt_rdata   = rdata_ff;
    nxt_err_rsp = 1'b0;
    nxt_ctrl    = ctrl_ff;
    nxt_mask    = mask_ff;
    nxt_stat    = stat_ff;
    if (nxt_rdy) begin
      case (paddr)
        `TPA_ADDR_CTRL:   nxt_rdata = {29'h0, ctrl_ff};
        `TPA_ADDR_STATUS: nxt_rdata = {27'h0, stat_ff};
        `TPA_ADDR_MASK:   nxt_rdata = {27'h0, mask_ff};
        `TPA_ADDR_INFO:   nxt_rdata = {22'h0, err_ff, prst_act_ff, mult_ff};
        default: begin
          nxt_rdata   = 32'h0;
          nxt_err_rsp = 1'b1;
        end
      endcase
    end
    if (commit && pwrite && !err_rsp_ff) begin
      case (paddr)
        `TPA_ADDR_CTRL:   nxt_ctrl = pwdata[2:0];
        `TPA_ADDR_STATUS: nxt_stat = stat_ff & ~pwdata[4:0];
        `TPA_ADDR_MASK:   nxt_mask = pwdata[4:0];
        default:          nxt_ctrl = ctrl_ff;
      endcase
    end
    nxt_stat = nxt_stat | {cfg_bad, lane_evt};            // set wins over clear
    nxt_irq  = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_ff    <= `TPA_CTRL_RST;
      stat_ff    <= `TPA_STATUS_RST;
      mask_ff    <= `TPA_MASK_RST;
      rdy_ff     <= 1'b0;
      err_rsp_ff <= 1'b0;
      rdata_ff   <= 32'h0;
      irq_ff     <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      stat_ff    <= nxt_stat;
      mask_ff    <= nxt_mask;
      rdy_ff     <= nxt_rdy;
      err_rsp_ff <= nxt_err_rsp;
      rdata_ff   <= nxt_rdata;
      irq_ff     <= nxt_irq;
    end
  end

  // ****************************************
  // outputs, all from flip-flops
  // ****************************************
  assign prdata                     = rdata_ff;
  assign pready                     = rdy_ff;
  assign pslverr                    = err_rsp_ff;
  assign enc_char_data              = enc_data_ff;
  assign enc_char_control           = enc_ctl_ff;
  assign enc_char_valid             = enc_vld_ff;
  assign lane_error_flag            = err_ff;
  assign character_rate_clock_out_p = ckp_ff;
  assign character_rate_clock_out_n = ckn_ff;
  assign synth_multiplier           = mult_ff;
  assign irq                        = irq_ff;

  // ****************************************
  // assertions
  // ****************************************
  property p_half_rate_fall;
    @(posedge sys_clk) disable iff (rst)
      (sel == TPA_SEL_LOW && rate && ref_fall) |-> wr_stb[LANES-1];
  endproperty
  a_half_rate_fall: assert property (p_half_rate_fall)
    else $error("falling reference edge not used at half rate");

  property p_mid_own_clock;
    @(posedge sys_clk) disable iff (rst)
      (sel == TPA_SEL_MID) |-> (wr_stb == lane_rise);
  endproperty
  a_mid_own_clock: assert property (p_mid_own_clock)
    else $error("mid select not using lane clocks");

  property p_two_low_samples;
    @(posedge sys_clk) disable iff (rst)
      $rose(prst_act_ff) |-> $past(prst_cnt_ff) == 2'h1 && $past(ref_rise);
  endproperty
  a_two_low_samples: assert property (p_two_low_samples)
    else $error("phase reset taken before two low samples");

  property p_bypass_no_recentre;
    @(posedge sys_clk) disable iff (rst)
      (bypass && $past(bypass))
        |-> (err_ff == '0 && !prst_act_ff && state_ff == TPA_ST_BYPASS);
  endproperty
  a_bypass_no_recentre: assert property (p_bypass_no_recentre)
    else $error("bypass reacted to phase reset");

  property p_run_frozen;
    @(posedge sys_clk) disable iff (rst)
      (state_ff == TPA_ST_RUN && !prst_act_ff) |=> !recentre;
  endproperty
  a_run_frozen: assert property (p_run_frozen)
    else $error("buffer moved while phase locked");

  property p_err_sticky;
    @(posedge sys_clk) disable iff (rst)
      (err_ff[0] && !lane_word_sync_sent[0] && !prst_act_ff && !bypass) |=> err_ff[0];
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("lane error flag dropped without cause");

  property p_err_set;
    @(posedge sys_clk) disable iff (rst) lane_evt[0] |=> err_ff[0] [*1];
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("buffer fault did not raise lane error");

  property p_clk_compl;
    @(posedge sys_clk) disable iff (rst) ##1 (ckp_ff != ckn_ff);
  endproperty
  a_clk_compl: assert property (p_clk_compl)
    else $error("output clock pair not complementary");

  property p_mult;
    @(posedge sys_clk) disable iff (rst)
      ##1 (mult_ff == ($past(rate) ? 5'h14 : 5'h0a));
  endproperty
  a_mult: assert property (p_mult)
    else $error("wrong multiplier for rate select");
endmodule

// ### verification/tpa_host_model.sv
// host side: reference clock, lane clocks, characters and phase reset
module tpa_host_model (
  input  wire logic            run,
  input  wire logic            prst_req,
  input  wire logic [3:0]      lane_stop,
  output logic                 ref_clk,
  output logic      [3:0]      lane_clk,
  output logic                 prst_n,
  output logic      [3:0][7:0] data,
  output logic      [3:0][1:0] ctl
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] cnt_ff = 10'h0;  // character counter
  // 125 ns reference, offset so it never lines up with sys_clk
  initial begin
    ref_clk = 1'b0;
    prst_n = 1'b1;
    #3;
    forever #62.5 ref_clk = run ? ~ref_clk : ref_clk;
  end
  // new character mid-phase so either edge captures it cleanly
  always @(ref_clk) begin
    cnt_ff <= #31 cnt_ff + 10'h1;
  end
  // lane clocks coherent with reference; stop only when told
  assign lane_clk = {4{ref_clk}} & ~lane_stop;
  assign data = {4{cnt_ff[7:0]}};
  assign ctl = {4{cnt_ff[9:8]}};
  // reset changes on falling edge, held many rising edges
  always @(negedge ref_clk) begin
    prst_n <= ~prst_req;
  end
endmodule

// ### verification/tb.sv
`include "tpa_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import tpa_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, run = 1, prst_req = 0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, serr, reference_clock_in, transmit_phase_reset_n, irq;
  logic character_rate_clock_out_p, character_rate_clock_out_n;
  logic [3:0] lane_input_clock, enc_char_valid, lane_error_flag, stop = 4'h0, sync_sent = 4'h0;
  logic [3:0][7:0] lane_char_data_in, enc_char_data;
  logic [3:0][1:0] lane_char_control_in, enc_char_control;
  logic [4:0] synth_multiplier;
  int failures = 0, check_count = 0;
  tpa_host_model host (.run, .prst_req, .lane_stop(stop), .ref_clk(reference_clock_in),
    .lane_clk(lane_input_clock), .prst_n(transmit_phase_reset_n),
    .data(lane_char_data_in), .ctl(lane_char_control_in));
  tpa_tx_input_clocking dut (.sys_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .reference_clock_in, .lane_input_clock,
    .transmit_phase_reset_n, .lane_char_data_in, .lane_char_control_in,
    .lane_word_sync_sent(sync_sent), .enc_char_data, .enc_char_control, .enc_char_valid,
    .lane_error_flag, .character_rate_clock_out_p, .character_rate_clock_out_n,
    .synth_multiplier, .irq);
  initial forever #5 sys_clk = ~sys_clk;
  // apb master: setup, access held until pready seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1 && n++ < 50);
    if (pready !== 1'b1) failures++;
    rd = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // next delivered character on one lane, bounded wait
  task get_char(input int l, output logic [9:0] d);
    int n;
    n = 0;
    do @(posedge sys_clk); while (enc_char_valid[l] !== 1'b1 && n++ < 400);
    if (enc_char_valid[l] !== 1'b1) failures++;
    d = {enc_char_control[l], enc_char_data[l]};
  endtask
  // control and data travel together, so the 10-bit step checks both
  task step(input int l, input logic [9:0] s);
    logic [9:0] a, b, dd;
    get_char(l, a);
    get_char(l, b);
    dd = b - a;
    `CHK(dd, s)
  endtask
  // phase reset pulse; checks the realign indicator while low and after
  task prst(input logic act);
    prst_req <= 1;
    repeat (60) @(posedge sys_clk);
    apb(0, `TPA_ADDR_INFO, 0);
    `CHK(rd[5], act)
    prst_req <= 0;
    repeat (60) @(posedge sys_clk);
    apb(0, `TPA_ADDR_INFO, 0);
    `CHK(rd[5], 1'b0)
  endtask
  // eight output clock periods in sys_clk cycles
  task clk_per(input int e);
    int n, k;
    logic pv;
    n = 0; k = 0; pv = 1;
    while (k < 9 && n < 3000) begin
      @(posedge sys_clk);
      if (character_rate_clock_out_p && !pv) begin k++; if (k == 1) n = 0; end
      pv = character_rate_clock_out_p;
      n++;
    end
    `CHK(n inside {[e - 3:e + 3]}, 1'b1)
    `CHK(character_rate_clock_out_n, ~character_rate_clock_out_p)
  endtask
  task t_reset;
    `CHK(synth_multiplier, 5'h0a)
    apb(0, `TPA_ADDR_STATUS, 0);
    `CHK(rd, 32'h0)
    apb(1, 8'h10, 32'hffffffff);
    `CHK(serr, 1'b1)
    $display("test reset done");
  endtask
  task t_bypass;
    apb(1, `TPA_ADDR_CTRL, 32'h0);
    prst(0);
    step(0, 10'h002);
    clk_per(100);
    $display("test bypass done");
  endtask
  task t_lanes;
    apb(1, `TPA_ADDR_CTRL, 32'h1);
    prst(1);
    step(3, 10'h002);
    apb(1, `TPA_ADDR_CTRL, 32'h2);
    stop <= 4'h2;
    step(1, 10'h002);
    $display("test lane select done");
  endtask
  task t_fault;
    apb(1, `TPA_ADDR_CTRL, 32'h1);
    repeat (300) @(posedge sys_clk);
    `CHK(lane_error_flag[1], 1'b1)
    apb(1, `TPA_ADDR_MASK, 32'h2);
    repeat (3) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    stop <= 4'h0;
    repeat (60) @(posedge sys_clk);
    sync_sent <= 4'h2;
    @(posedge sys_clk);
    sync_sent <= 4'h0;
    repeat (2) @(posedge sys_clk);
    `CHK(lane_error_flag[1], 1'b0)
    prst(1);
    `CHK(lane_error_flag, 4'h0)
    apb(1, `TPA_ADDR_STATUS, 32'h1f);
    apb(0, `TPA_ADDR_STATUS, 0);
    `CHK(rd, 32'h0)
    `CHK(irq, 1'b0)
    $display("test fault done");
  endtask
  task t_half;
    apb(1, `TPA_ADDR_CTRL, 32'h4);
    prst(1);
    `CHK(synth_multiplier, 5'h14)
    step(2, 10'h001);
    clk_per(50);
    $display("test half rate done");
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 0;
    t_reset;
    t_bypass;
    t_lanes;
    t_fault;
    t_half;
    results;
  end
  initial begin
    #300us;
    failures++;
    results;
  end
endmodule
